// File: core/net_defs.svh
`ifndef NET_DEFS_SVH
`define NET_DEFS_SVH

// ****************************************
// network constants
// ****************************************
`define MAX_SLAVES        5'd31
`define MASTER_ADDR       5'h00
`define CHAR_FOUND        8'h53
`define CHAR_TIMEOUT      8'h54
`define CHAR_ZERO         8'h30
`define TIMEOUT_US        100
`define CLK_MHZ           10
`define TIMEOUT_CYCLES    (`TIMEOUT_US * `CLK_MHZ)
`define POLL_TAG          8'h50

`endif

// File: core/net_pkg.sv
package net_pkg;
  typedef struct packed {
    logic       valid;
    logic [4:0] addr;
    logic [7:0] data;
  } net_word_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_PROBE,
    ST_WAIT,
    ST_REPORT,
    ST_POLL,
    ST_COLLECT,
    ST_NEXT
  } master_state_t;
endpackage

// File: core/polled_multidrop_network.sv
`timescale 1ns/1ps
`include "net_defs.svh"

module polled_multidrop_network #(
  parameter int TIMEOUT_CYCLES = `TIMEOUT_CYCLES
) (
  input  wire logic              clk_in,
  input  wire logic              rst_n_in,
  input  wire logic [4:0]        station_addr_in,
  input  wire logic              master_sel_in,
  input  wire logic              bus_rx_valid_in,
  input  wire logic [7:0]        bus_rx_data_in,
  input  wire logic              bus_tx_ready_in,
  output net_pkg::net_word_t     bus_tx_out,
  input  wire logic              host_ready_in,
  output logic                   host_valid_out,
  output logic [7:0]             host_data_out,
  input  wire logic              slave_data_valid_in,
  input  wire logic [7:0]        slave_data_in,
  output logic                   slave_data_ready_out,
  output logic                   is_master_out,
  output logic                   init_done_out
);
  import net_pkg::*;

  // ****************************************
  // role and configuration
  // ****************************************
  // address is a strap from outside: two flops first
  logic [4:0] addr_sync1;
  logic [4:0] addr_sync2;
  logic [4:0] last_addr;
  logic       role_sync1;
  logic       role_sync2;

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      addr_sync1 <= 5'h00;
      addr_sync2 <= 5'h00;
      role_sync1 <= 1'b0;
      role_sync2 <= 1'b0;
    end
    else
    begin
      addr_sync1 <= station_addr_in;
      addr_sync2 <= addr_sync1;
      role_sync1 <= master_sel_in;
      role_sync2 <= role_sync1;
    end
  end

  logic master_mode;
  // role strap picks master; the setting then means highest slave, not own address
  assign master_mode = role_sync2;
  assign is_master_out = master_mode;
  // 5-bit setting already caps count at 31
  assign last_addr = addr_sync2;

  // ****************************************
  // master sequencer
  // ****************************************
  master_state_t state;
  logic [4:0]  cur;
  logic [31:0] dead;
  logic        found;
  logic        probing;
  logic [31:0] timer;
  logic [1:0]  rpt_idx;
  logic [7:0]  rpt_chars [0:2];
  logic [4:0]  highest;

  // reporting digits, tens then units then status letter
  always_comb
  begin
    rpt_chars[0] = `CHAR_ZERO + ((cur >= 5'd30) ? 8'h03 :
                   (cur >= 5'd20) ? 8'h02 : (cur >= 5'd10) ? 8'h01 : 8'h00);
    rpt_chars[1] = `CHAR_ZERO + 8'(cur - ((cur >= 5'd30) ? 5'd30 :
                   (cur >= 5'd20) ? 5'd20 : (cur >= 5'd10) ? 5'd10 : 5'd0));
    rpt_chars[2] = found ? `CHAR_FOUND : `CHAR_TIMEOUT;
  end

  logic rx_hit;
  assign rx_hit = bus_rx_valid_in && (bus_rx_data_in[4:0] == cur);

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state         <= ST_IDLE;
      cur           <= 5'h00;
      dead          <= '0;
      found         <= 1'b0;
      probing       <= 1'b1;
      timer         <= '0;
      rpt_idx       <= 2'd0;
      highest       <= 5'h00;
      init_done_out <= 1'b0;
    end
    else if (!master_mode)
    begin
      state         <= ST_IDLE;
      probing       <= 1'b1;
      init_done_out <= 1'b0;
    end
    else
    begin
      case (state)
        ST_IDLE:
        begin
          highest <= last_addr;
          cur     <= 5'd1;
          dead    <= '0;
          if (last_addr != 5'h00)
            state <= probing ? ST_PROBE : ST_POLL;
        end
        ST_PROBE, ST_POLL:
        begin
          if (dead[cur])
            state <= ST_NEXT;
          else if (bus_tx_ready_in)
          begin
            timer <= '0;
            state <= (state == ST_PROBE) ? ST_WAIT : ST_COLLECT;
          end
        end
        ST_WAIT:
        begin
          if (rx_hit)
          begin
            found   <= 1'b1;
            rpt_idx <= 2'd0;
            state   <= ST_REPORT;
          end
          else if (timer == TIMEOUT_CYCLES - 1)
          begin
            found     <= 1'b0;
            dead[cur] <= 1'b1;
            rpt_idx   <= 2'd0;
            state     <= ST_REPORT;
          end
          else
            timer <= timer + 32'd1;
        end
        ST_REPORT:
        begin
          if (host_ready_in)
          begin
            rpt_idx <= rpt_idx + 2'd1;
            if (rpt_idx == 2'd2)
              state <= ST_NEXT;
          end
        end
        ST_COLLECT:
        begin
          // one station at a time; stream ends on reply or timeout
          if (rx_hit || timer == TIMEOUT_CYCLES - 1)
            state <= ST_NEXT;
          else
            timer <= timer + (bus_rx_valid_in ? 32'd0 : 32'd1);
        end
        ST_NEXT:
        begin
          if (cur >= highest)
          begin
            cur           <= 5'd1;
            probing       <= 1'b0;
            init_done_out <= 1'b1;
            state         <= ST_POLL;
          end
          else
          begin
            cur   <= cur + 5'd1;
            state <= probing ? ST_PROBE : ST_POLL;
          end
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // ****************************************
  // bus request and host stream
  // ****************************************
  logic slave_polled;
  // a slave left at address zero stays silent: zero belongs to the master
  assign slave_polled = !master_mode && bus_rx_valid_in &&
                        (addr_sync2 != `MASTER_ADDR) &&
                        (bus_rx_data_in == {3'b000, addr_sync2});

  logic slave_armed;
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      slave_armed <= 1'b0;
    else if (slave_polled)
      slave_armed <= 1'b1;
    else if (slave_armed && slave_data_valid_in && bus_tx_ready_in)
      slave_armed <= 1'b0;
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      bus_tx_out <= '0;
    else if (master_mode)
    begin
      bus_tx_out.valid <= (state == ST_PROBE || state == ST_POLL) && !dead[cur];
      bus_tx_out.addr  <= cur;
      bus_tx_out.data  <= `POLL_TAG;
    end
    else
    begin
      // reply only in answer to this station's poll
      bus_tx_out.valid <= slave_armed && slave_data_valid_in;
      bus_tx_out.addr  <= `MASTER_ADDR;
      bus_tx_out.data  <= slave_data_in;
    end
  end

  assign slave_data_ready_out = !master_mode && slave_armed && bus_tx_ready_in;

  always_comb
  begin
    host_valid_out = 1'b0;
    host_data_out  = 8'h00;
    if (master_mode && state == ST_REPORT)
    begin
      host_valid_out = 1'b1;
      host_data_out  = rpt_chars[rpt_idx];
    end
    else if (master_mode && state == ST_COLLECT && bus_rx_valid_in && !rx_hit)
    begin
      host_valid_out = 1'b1;
      host_data_out  = bus_rx_data_in;
    end
  end
endmodule // polled_multidrop_network

// File: sim/polled_multidrop_network_monitor.sv
`timescale 1ns/1ps
module polled_multidrop_network_monitor (
  input wire logic               clk_in,
  input wire logic               rst_n_in,
  input wire logic               bus_rx_valid_in,
  input wire net_pkg::net_word_t bus_tx_out,
  input wire logic               host_ready_in,
  input wire logic               host_valid_out,
  input wire logic [7:0]         host_data_out,
  input wire logic               is_master_out,
  input wire logic               init_done_out
);
  import net_pkg::*;
  // ***
  // checks
  // ***
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  logic heard;
  // a slave stays mute until some byte reached it
  always_ff @(posedge clk_in or negedge rst_n_in)
    if (!rst_n_in)
      heard <= 1'b0;
    else if (bus_rx_valid_in)
      heard <= 1'b1;
  sequence s_stall;
    host_valid_out && !host_ready_in;
  endsequence
  property p_tag;
    is_master_out && bus_tx_out.valid |-> bus_tx_out.data == 8'h50;
  endproperty
  a_tag: assert property (p_tag) else $error("bad poll byte");
  property p_nz;
    is_master_out && bus_tx_out.valid |-> bus_tx_out.addr != 5'h00;
  endproperty
  a_nz: assert property (p_nz) else $error("poll to zero");
  property p_rep;
    !is_master_out && bus_tx_out.valid |-> bus_tx_out.addr == 5'h00;
  endproperty
  a_rep: assert property (p_rep) else $error("reply not to zero");
  property p_hold;
    s_stall |=> host_valid_out && $stable(host_data_out);
  endproperty
  a_hold: assert property (p_hold) else $error("host byte dropped");
  property p_fmt;
    is_master_out && host_valid_out && !init_done_out
      |-> host_data_out inside {8'h53, 8'h54, [8'h30:8'h39]};
  endproperty
  a_fmt: assert property (p_fmt) else $error("bad report char");
  property p_mute;
    !is_master_out && !heard |-> !bus_tx_out.valid;
  endproperty
  a_mute: assert property (p_mute) else $error("slave spoke");
  property p_done;
    $rose(init_done_out) |-> is_master_out;
  endproperty
  a_done: assert property (p_done) else $error("init in slave");
  property p_role;
    !is_master_out |-> !init_done_out;
  endproperty
  a_role: assert property (p_role) else $error("slave probing");
endmodule // polled_multidrop_network_monitor
bind polled_multidrop_network polled_multidrop_network_monitor mon (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .bus_rx_valid_in(bus_rx_valid_in),
  .bus_tx_out(bus_tx_out), .host_ready_in(host_ready_in),
  .host_valid_out(host_valid_out), .host_data_out(host_data_out),
  .is_master_out(is_master_out), .init_done_out(init_done_out));

// File: sim/slave_bus_model.sv
`timescale 1ns/1ps
module slave_bus_model (
  input  wire logic               clk_in,
  input  wire net_pkg::net_word_t tx_in,
  input  wire logic               done_in,
  output logic                    rx_valid_out,
  output logic [7:0]              rx_data_out,
  output logic                    bad_out
);
  import net_pkg::*;
  // ***
  // stations 1 and 3 alive, delay = address
  // ***
  logic seen;
  initial
  begin
    rx_valid_out = 1'b0;
    rx_data_out = 8'h00;
    bad_out = 1'b0;
    seen = 1'b0;
  end
  // bytes change on the edge by nonblocking update, so bench sampling never races them
  task reply(input logic [4:0] a, input logic d);
    repeat (a) @(posedge clk_in);
    if (d)
    begin
      rx_valid_out <= 1'b1;
      rx_data_out  <= 8'hA0;
      @(posedge clk_in);
    end
    rx_valid_out <= 1'b1;
    rx_data_out  <= {3'h0, a};
    @(posedge clk_in);
    rx_valid_out <= 1'b0;
    rx_data_out  <= ~{3'h0, a}; // released line shows no stale byte
  endtask
  always @(posedge clk_in)
  begin
    if (tx_in.valid && !seen && tx_in.addr != 5'h00)
    begin
      if (tx_in.addr == 5'd1 || tx_in.addr == 5'd3)
        fork reply(tx_in.addr, done_in); join_none
      else if (done_in)
        bad_out = 1'b1;
    end
    seen = tx_in.valid;
  end
endmodule // slave_bus_model

// File: sim/polled_multidrop_network_tb.sv
`timescale 1ns/1ps
module polled_multidrop_network_tb;
  import net_pkg::*;
  logic       clk_in, rst_n_in, host_ready_in, b_v, sd_v, m_v, hv, is_m, done, bad;
  logic       role, sd_r;
  logic [4:0] addr;
  logic [7:0] b_d, sd_d, m_d, hd;
  net_word_t  tx;
  int         miscompares, cmp_count, n;
  polled_multidrop_network #(.TIMEOUT_CYCLES(20)) uut (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .station_addr_in(addr), .master_sel_in(role),
    .bus_rx_valid_in(m_v | b_v), .bus_rx_data_in(b_v ? b_d : m_d),
    .bus_tx_ready_in(1'b1), .bus_tx_out(tx), .host_ready_in(host_ready_in),
    .host_valid_out(hv), .host_data_out(hd), .slave_data_valid_in(sd_v),
    .slave_data_in(sd_d), .slave_data_ready_out(sd_r), .is_master_out(is_m),
    .init_done_out(done));
  slave_bus_model far (.clk_in(clk_in), .tx_in(tx), .done_in(done),
    .rx_valid_out(m_v), .rx_data_out(m_d), .bad_out(bad));
  // ***
  // tasks
  // ***
  task print_verdict;
    if (miscompares == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e)
    begin
      miscompares++;
      $display("unexpected at %0t: %h vs %h", $time, g, e);
    end
  endtask
  task step(input int k);
    repeat (k) @(posedge clk_in);
    #1;
  endtask
  task get(input logic [7:0] e);
    for (n = 0; !(hv && host_ready_in) && n < 3000; n++)
      step(1);
    if (n == 3000)
    begin
      miscompares++;
      print_verdict;
    end
    chk(hd, e);
    step(1);
  endtask
  task rst(input logic [4:0] a, input logic m);
    addr = a;
    role = m;
    rst_n_in = 1'b0;
    step(2);
    rst_n_in = 1'b1;
    step(3); // strap needs two edges to settle
  endtask
  task t_probe;
    step(40); // host stalls first
    host_ready_in = 1'b1;
    for (int k = 1; k <= 31; k++)
    begin
      get(8'h30 + k / 10);
      get(8'h30 + k % 10);
      get((k == 1 || k == 3) ? 8'h53 : 8'h54);
    end
    step(3);
    chk({7'h00, done}, 8'h01);
  endtask
  task t_poll;
    repeat (6) get(8'hA0);
    chk({7'h00, bad}, 8'h00);
  endtask
  task t_slave;
    rst(5'd5, 1'b0);
    chk({7'h00, is_m}, 8'h00);
    sd_v = 1'b1;
    sd_d = 8'h77;
    b_d = 8'h06;
    b_v = 1'b1;
    step(1);
    b_v = 1'b0;
    step(10);
    chk({7'h00, tx.valid}, 8'h00);
    chk({7'h00, sd_r}, 8'h00);
    b_d = 8'h05;
    b_v = 1'b1;
    step(1);
    b_v = 1'b0;
    chk({7'h00, sd_r}, 8'h01);
    for (n = 0; tx.valid !== 1'b1 && n < 20; n++)
      step(1);
    chk({7'h00, tx.valid}, 8'h01);
    chk({3'h0, tx.addr}, 8'h00);
    chk(tx.data, 8'h77);
  endtask
  task t_zero;
    rst(5'd0, 1'b0);
    sd_v = 1'b1;
    b_d = 8'h00;
    b_v = 1'b1;
    step(1);
    b_v = 1'b0;
    chk({7'h00, sd_r}, 8'h00);
    step(1);
    chk({7'h00, tx.valid}, 8'h00);
  endtask
  initial
  begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  initial
  begin
    {host_ready_in, b_v, sd_v, b_d, sd_d} = '0;
    rst(5'd31, 1'b1);
    t_probe;
    t_poll;
    t_slave;
    t_zero;
    print_verdict;
  end
endmodule // polled_multidrop_network_tb
